// ===== rtl/pwm16_pkg.sv
// Shared constants for the 16-bit timer waveform generator
package pwm16_pkg;

  // Register bus
  localparam int          ADDR_W         = 3;
  localparam int          DATA_W         = 16;
  localparam logic [2:0]  OFF_CTRL       = 3'h0;
  localparam logic [2:0]  OFF_CMP_A      = 3'h1;
  localparam logic [2:0]  OFF_CMP_B      = 3'h2;
  localparam logic [2:0]  OFF_CAPTURE    = 3'h3;
  localparam logic [2:0]  OFF_COUNT      = 3'h4;
  localparam logic [2:0]  OFF_FLAGS      = 3'h5;

  // Control register fields
  localparam int          CTRL_MODE_LSB  = 0;
  localparam int          CTRL_COMA_LSB  = 4;
  localparam int          CTRL_COMB_LSB  = 6;
  localparam int          CTRL_CS_LSB    = 8;
  localparam int          CTRL_DIR_LSB   = 11;
  localparam logic [12:0] CTRL_RESET     = 13'h0000;

  // Flag register fields
  localparam int          FLG_OVF        = 0;
  localparam int          FLG_CMP_A      = 1;
  localparam int          FLG_CMP_B      = 2;
  localparam int          FLG_CAPTURE    = 3;

  // Reset value of the value registers and the 16-bit count maximum
  localparam logic [15:0] VALUE_RESET    = 16'h0000;
  localparam logic [15:0] COUNT_MAX      = 16'hffff;

  // Waveform mode codes
  localparam logic [3:0]  MODE_PC8       = 4'h1;
  localparam logic [3:0]  MODE_PC9       = 4'h2;
  localparam logic [3:0]  MODE_PC10      = 4'h3;
  localparam logic [3:0]  MODE_FAST8     = 4'h5;
  localparam logic [3:0]  MODE_FAST9     = 4'h6;
  localparam logic [3:0]  MODE_FAST10    = 4'h7;
  localparam logic [3:0]  MODE_PC_CAP    = 4'ha;
  localparam logic [3:0]  MODE_PC_CMPA   = 4'hb;
  localparam logic [3:0]  MODE_FAST_CAP  = 4'he;
  localparam logic [3:0]  MODE_FAST_CMPA = 4'hf;

  // Fixed TOP values
  localparam logic [15:0] TOP_8BIT       = 16'h00ff;
  localparam logic [15:0] TOP_9BIT       = 16'h01ff;
  localparam logic [15:0] TOP_10BIT      = 16'h03ff;

  // Output action select codes
  localparam logic [1:0]  ACT_NONE       = 2'h0;
  localparam logic [1:0]  ACT_TOGGLE     = 2'h1;
  localparam logic [1:0]  ACT_NONINV     = 2'h2;
  localparam logic [1:0]  ACT_INV        = 2'h3;

  // Prescaler selects and their masks (divide minus one)
  localparam logic [2:0]  CS_STOP        = 3'h0;
  localparam logic [2:0]  CS_DIV1        = 3'h1;
  localparam logic [2:0]  CS_DIV8        = 3'h2;
  localparam logic [2:0]  CS_DIV64       = 3'h3;
  localparam logic [2:0]  CS_DIV256      = 3'h4;
  localparam logic [2:0]  CS_DIV1024     = 3'h5;
  localparam logic [9:0]  PRE_MASK8      = 10'h007;
  localparam logic [9:0]  PRE_MASK64     = 10'h03f;
  localparam logic [9:0]  PRE_MASK256    = 10'h0ff;
  localparam logic [9:0]  PRE_MASK1024   = 10'h3ff;

endpackage : pwm16_pkg

// ===== rtl/timer16_pwm.sv
// 16-bit timer with fast and phase correct PWM on two compare channels
`timescale 1ns/10ps
module timer16_pwm
  import pwm16_pkg::*;
(
  // Clock and reset
  input  wire logic                          CLK,
  input  wire logic                          RST_N,
  // Register port
  input  wire logic [pwm16_pkg::ADDR_W-1:0]  BUS_ADDR,
  input  wire logic [pwm16_pkg::DATA_W-1:0]  BUS_WDATA,
  input  wire logic                          BUS_WR,
  input  wire logic                          BUS_RD,
  output logic      [pwm16_pkg::DATA_W-1:0]  BUS_RDATA,
  // Waveform pins
  output logic                               WAVE_A_O,
  output logic                               WAVE_A_OE,
  output logic                               WAVE_B_O,
  output logic                               WAVE_B_OE
);
  import pwm16_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [3:0]  waveform_mode_select;
  logic [1:0]  output_action_select [2];
  logic [2:0]  clock_select;
  logic [1:0]  pin_direction_control;
  logic [12:0] ctrl_q;
  logic [15:0] compare_buf_q [2];
  logic [15:0] compare_value_q [2];
  logic [15:0] capture_value_q;
  logic [15:0] counter_value_q;
  logic        down_q;
  logic [3:0]  flags_q;
  logic [3:0]  flags_set;
  logic [9:0]  presc_q;
  logic [9:0]  presc_mask;
  logic        tick;
  logic [15:0] top;
  logic        at_top;
  logic        is_fast;
  logic        is_pc;
  logic        is_fixed;
  logic        upd;
  logic        wr_count;
  logic [15:0] cmp_wdata;
  logic [1:0]  match;
  logic [1:0]  wave_q;

  assign waveform_mode_select     = ctrl_q[CTRL_MODE_LSB +: 4];
  assign output_action_select[0]  = ctrl_q[CTRL_COMA_LSB +: 2];
  assign output_action_select[1]  = ctrl_q[CTRL_COMB_LSB +: 2];
  assign clock_select             = ctrl_q[CTRL_CS_LSB +: 3];
  assign pin_direction_control    = ctrl_q[CTRL_DIR_LSB +: 2];
  assign wr_count                 = BUS_WR && (BUS_ADDR == OFF_COUNT);

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= CTRL_RESET;
    end else if (BUS_WR && (BUS_ADDR == OFF_CTRL)) begin
      ctrl_q <= BUS_WDATA[12:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler
  always_comb begin
    unique case (clock_select)
      CS_DIV8:    presc_mask = PRE_MASK8;
      CS_DIV64:   presc_mask = PRE_MASK64;
      CS_DIV256:  presc_mask = PRE_MASK256;
      CS_DIV1024: presc_mask = PRE_MASK1024;
      default:    presc_mask = '0;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + 10'h001;
    end
  end

  // Stopped or unused selects give no tick
  assign tick = (clock_select != CS_STOP) && (clock_select <= CS_DIV1024) &&
                ((presc_q & presc_mask) == presc_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and TOP selection
  always_comb begin
    is_fast  = 1'b0;
    is_pc    = 1'b0;
    is_fixed = 1'b0;
    top      = COUNT_MAX;
    unique case (waveform_mode_select)
      MODE_PC8, MODE_FAST8: begin
        top = TOP_8BIT;
        is_fixed = 1'b1;
      end
      MODE_PC9, MODE_FAST9: begin
        top = TOP_9BIT;
        is_fixed = 1'b1;
      end
      MODE_PC10, MODE_FAST10: begin
        top = TOP_10BIT;
        is_fixed = 1'b1;
      end
      MODE_PC_CAP, MODE_FAST_CAP: top = capture_value_q;
      MODE_PC_CMPA, MODE_FAST_CMPA: top = compare_value_q[0];
      default: top = COUNT_MAX;
    endcase
    unique case (waveform_mode_select)
      MODE_FAST8, MODE_FAST9, MODE_FAST10, MODE_FAST_CAP, MODE_FAST_CMPA: is_fast = 1'b1;
      MODE_PC8, MODE_PC9, MODE_PC10, MODE_PC_CAP, MODE_PC_CMPA: is_pc = 1'b1;
      default: is_fast = 1'b0;
    endcase
  end

  assign at_top = (counter_value_q == top);
  // Buffer load point: fast at TOP clear, phase correct when leaving TOP
  assign upd = tick && at_top && (is_fast || (is_pc && !down_q));
  // Fixed widths mask the written compare value
  assign cmp_wdata = is_fixed ? (BUS_WDATA & top) : BUS_WDATA;

  ////////////////////////////////////////////////////////////////////////////
  // Counter and direction
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      counter_value_q <= VALUE_RESET;
      down_q          <= 1'b0;
    end else if (wr_count) begin
      counter_value_q <= BUS_WDATA;
    end else if (tick) begin
      if (is_fast) begin
        // Missed TOP simply wraps through the 16-bit maximum
        counter_value_q <= at_top ? VALUE_RESET : counter_value_q + 16'h0001;
      end else if (is_pc) begin
        if (down_q) begin
          counter_value_q <= (counter_value_q == VALUE_RESET) ? 16'h0001
                                                               : counter_value_q - 16'h0001;
          if (counter_value_q <= 16'h0001) begin
            down_q <= 1'b0;
          end
        end else if (at_top && (top != VALUE_RESET)) begin
          down_q          <= 1'b1;
          counter_value_q <= counter_value_q - 16'h0001;
        end else begin
          counter_value_q <= counter_value_q + 16'h0001;
        end
      end else begin
        counter_value_q <= counter_value_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture value, unbuffered
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      capture_value_q <= VALUE_RESET;
    end else if (BUS_WR && (BUS_ADDR == OFF_CAPTURE)) begin
      capture_value_q <= BUS_WDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare channels
  for (genvar i = 0; i < 2; i++) begin : g_chan
    localparam logic [2:0] OFF = (i == 0) ? OFF_CMP_A : OFF_CMP_B;

    assign match[i] = tick && (counter_value_q == compare_value_q[i]);

    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        compare_buf_q[i]   <= VALUE_RESET;
        compare_value_q[i] <= VALUE_RESET;
      end else begin
        if (BUS_WR && (BUS_ADDR == OFF)) begin
          compare_buf_q[i] <= cmp_wdata;
        end
        if (BUS_WR && (BUS_ADDR == OFF) && !is_fast && !is_pc) begin
          compare_value_q[i] <= cmp_wdata;
        end else if (upd) begin
          compare_value_q[i] <= compare_buf_q[i];
        end
      end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        wave_q[i] <= 1'b0;
      end else if (tick && is_fast) begin
        unique case (output_action_select[i])
          ACT_NONINV: begin
            if (at_top) begin
              wave_q[i] <= 1'b1;
            end else if (match[i]) begin
              wave_q[i] <= 1'b0;
            end
          end
          ACT_INV: begin
            if (at_top) begin
              wave_q[i] <= 1'b0;
            end else if (match[i]) begin
              wave_q[i] <= 1'b1;
            end
          end
          ACT_TOGGLE: begin
            if ((i == 0) && match[i]) begin
              wave_q[i] <= !wave_q[i];
            end
          end
          ACT_NONE: wave_q[i] <= wave_q[i];
        endcase
      end else if (tick && is_pc && match[i]) begin
        // A match at TOP counts as the falling side
        unique case (output_action_select[i])
          ACT_NONINV: wave_q[i] <= down_q || at_top;
          ACT_INV:    wave_q[i] <= !(down_q || at_top);
          default:    wave_q[i] <= wave_q[i];
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags, write one to clear, set wins
  always_comb begin
    flags_set              = '0;
    flags_set[FLG_OVF]     = tick && ((is_fast && at_top) ||
                             (is_pc && down_q && (counter_value_q == 16'h0001)) ||
                             (!is_fast && !is_pc && (counter_value_q == COUNT_MAX)));
    flags_set[FLG_CMP_A]   = match[0] ||
                             (upd && ((waveform_mode_select == MODE_FAST_CMPA) ||
                                      (waveform_mode_select == MODE_PC_CMPA)));
    flags_set[FLG_CMP_B]   = match[1];
    flags_set[FLG_CAPTURE] = upd && ((waveform_mode_select == MODE_FAST_CAP) ||
                                     (waveform_mode_select == MODE_PC_CAP));
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_q <= '0;
    end else if (BUS_WR && (BUS_ADDR == OFF_FLAGS)) begin
      flags_q <= (flags_q & ~BUS_WDATA[3:0]) | flags_set;
    end else begin
      flags_q <= flags_q | flags_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      BUS_RDATA <= '0;
    end else if (BUS_RD) begin
      unique case (BUS_ADDR)
        OFF_CTRL:    BUS_RDATA <= {3'h0, ctrl_q};
        OFF_CMP_A:   BUS_RDATA <= compare_buf_q[0];
        OFF_CMP_B:   BUS_RDATA <= compare_buf_q[1];
        OFF_CAPTURE: BUS_RDATA <= capture_value_q;
        OFF_COUNT:   BUS_RDATA <= counter_value_q;
        OFF_FLAGS:   BUS_RDATA <= {12'h000, flags_q};
        default:     BUS_RDATA <= '0;
      endcase
    end else begin
      BUS_RDATA <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins
  assign WAVE_A_O  = wave_q[0];
  assign WAVE_B_O  = wave_q[1];
  assign WAVE_A_OE = pin_direction_control[0];
  assign WAVE_B_OE = pin_direction_control[1];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_fast_ovf;
    tick && is_fast && at_top |=> flags_q[FLG_OVF];
  endproperty
  a_fast_ovf: assert property (p_fast_ovf) else $error("overflow flag missing at TOP");

  property p_top_flag;
    tick && at_top && (waveform_mode_select == MODE_FAST_CAP) |=> flags_q[FLG_CAPTURE];
  endproperty
  a_top_flag: assert property (p_top_flag) else $error("capture flag missing at TOP");

  property p_mask;
    BUS_WR && (BUS_ADDR == OFF_CMP_A) && (waveform_mode_select == MODE_FAST8)
      |=> compare_buf_q[0][15:8] == 8'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("compare bits above width kept");

  property p_load;
    upd && !BUS_WR |=> compare_value_q[0] == $past(compare_buf_q[0]);
  endproperty
  a_load: assert property (p_load) else $error("buffer not loaded at TOP");

  // Channel B carries the non-inverted table runs, so it is watched here
  property p_fast_clear;
    tick && is_fast && at_top && !wr_count |=> (counter_value_q == VALUE_RESET) &&
      (($past(output_action_select[1]) != ACT_NONINV) || WAVE_B_O);
  endproperty
  a_fast_clear: assert property (p_fast_clear) else $error("fast clear wrong");

  property p_pc_turn;
    tick && is_pc && !down_q && at_top && (top != 16'h0000) && !wr_count
      |=> down_q && (counter_value_q == $past(counter_value_q) - 16'h0001);
  endproperty
  a_pc_turn: assert property (p_pc_turn) else $error("no turn at TOP");

  property p_pc_up_clear;
    tick && is_pc && !down_q && !at_top && match[1] &&
      (output_action_select[1] == ACT_NONINV) |=> !WAVE_B_O;
  endproperty
  a_pc_up_clear: assert property (p_pc_up_clear) else $error("up match not clearing");

  property p_pc_ovf;
    tick && is_pc && down_q && (counter_value_q == 16'h0001) && !wr_count
      |=> flags_q[FLG_OVF] && (counter_value_q == VALUE_RESET) && !down_q;
  endproperty
  a_pc_ovf: assert property (p_pc_ovf) else $error("no overflow at BOTTOM");

  property p_match_b;
    match[1] |=> flags_q[FLG_CMP_B];
  endproperty
  a_match_b: assert property (p_match_b) else $error("compare flag B missing");

  property p_div8;
    (clock_select == CS_DIV8) && tick && !BUS_WR |=> !tick [*7];
  endproperty
  a_div8: assert property (p_div8) else $error("divide by eight wrong");

  c_fast_cycle: cover property (tick && is_fast && at_top ##1 flags_q[FLG_OVF]);
  c_pc_turn:    cover property (tick && is_pc && at_top && !down_q ##1 down_q);
  c_toggle:     cover property (tick && is_fast && match[0] &&
                                (output_action_select[0] == ACT_TOGGLE));
  c_pc_bottom:  cover property (tick && is_pc && down_q && (counter_value_q == 16'h0001));

endmodule : timer16_pwm

// ===== bench/pwm_load_model.sv
// Load on one waveform pin: measures driven high time and rising edges
`timescale 1ns/10ps
module pwm_load_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Pin side
  input  wire logic        level,
  input  wire logic        drive,
  // Measurement
  input  wire logic        clear,
  output logic      [15:0] high_cnt,
  output logic      [15:0] rise_cnt
);
  logic pin_q;

  // Released pin has no pull: show inverse of last level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= drive ? level : ~pin_q;
    end
  end

  // Only a driven pin counts toward the measurement
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_cnt <= 16'h0000;
      rise_cnt <= 16'h0000;
    end else if (clear) begin
      high_cnt <= 16'h0000;
      rise_cnt <= 16'h0000;
    end else if (drive) begin
      high_cnt <= high_cnt + {15'h0000, level};
      rise_cnt <= rise_cnt + {15'h0000, level & ~pin_q};
    end
  end
endmodule : pwm_load_model

// ===== bench/tb_timer16_pwm.sv
// Self-checking bench for the 16-bit timer PWM generator
`timescale 1ns/10ps
module tb_timer16_pwm;
  import pwm16_pkg::*;
  typedef struct packed {
    logic [3:0]  mode;
    logic [1:0]  act;
    logic [2:0]  cs;
    logic [15:0] cmp;
    logic [15:0] per;
    logic [15:0] hi;
    logic [15:0] rise;
  } case_s;
  logic              clk, rst_n, bus_wr, bus_rd, clr;
  logic [ADDR_W-1:0] bus_addr;
  logic [15:0]       bus_wdata, bus_rdata, rd_q, hi_a, rise_a, hi_b, rise_b;
  logic              wave_a, wave_a_oe, wave_b, wave_b_oe;
  int                bad_count, checks, cyc;
  case_s             tbl[19];
  logic [3:0]        fm[6] = '{MODE_FAST8, MODE_FAST9, MODE_FAST10, MODE_PC8, MODE_PC9, MODE_PC10};
  logic [15:0]       ft[6] = '{TOP_8BIT, TOP_9BIT, TOP_10BIT, TOP_8BIT, TOP_9BIT, TOP_10BIT};

  timer16_pwm uut (.CLK(clk), .RST_N(rst_n), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata),
    .BUS_WR(bus_wr), .BUS_RD(bus_rd), .BUS_RDATA(bus_rdata), .WAVE_A_O(wave_a),
    .WAVE_A_OE(wave_a_oe), .WAVE_B_O(wave_b), .WAVE_B_OE(wave_b_oe));
  pwm_load_model load_a (.clk(clk), .rst_n(rst_n), .level(wave_a), .drive(wave_a_oe),
    .clear(clr), .high_cnt(hi_a), .rise_cnt(rise_a));
  pwm_load_model load_b (.clk(clk), .rst_n(rst_n), .level(wave_b), .drive(wave_b_oe),
    .clear(clr), .high_cnt(hi_b), .rise_cnt(rise_b));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] ctrl(input logic [3:0] m, input logic [1:0] aa,
                                       input logic [1:0] ab, input logic [2:0] cs,
                                       input logic da);
    return {3'h0, 1'b1, da, cs, ab, aa, m};
  endfunction : ctrl

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    rd_q = bus_rdata;
  endtask : rd

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [15:0] e);
    rd(a);
    chk(what, e, rd_q);
  endtask : rdchk

  task automatic measure(input int w);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (w) @(posedge clk);
    #1;
  endtask : measure

  task automatic run_case(input case_s c);
    wr(OFF_CTRL, ctrl(c.mode, ACT_NONE, c.act, CS_STOP, 1'b0));
    wr(OFF_COUNT, 16'h0000);
    wr(OFF_CMP_B, c.cmp);
    wr(OFF_CTRL, ctrl(c.mode, ACT_NONE, c.act, c.cs, 1'b0));
    repeat (2 * int'(c.per)) @(posedge clk);
    measure(2 * int'(c.per));
    chk("pin_a_enable", 16'h0000, {15'h0000, wave_a_oe});
    if (c.hi !== 16'hffff) chk("high_time", c.hi, hi_b);
    chk("rising_edges", c.rise, rise_b);
  endtask : run_case

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard, well above the expected run
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 80000) begin
        bad_count++;
        $display("timeout reached");
        report_and_stop();
      end
    end
  end

  initial begin
    {rst_n, bus_wr, bus_rd, clr, bus_addr, bus_wdata} = '0;
    bad_count = 0;
    checks    = 0;
    tbl = '{
      '{MODE_FAST_CAP, ACT_NONINV, CS_DIV1,  16'h0004, 16'd16,   16'd10,   16'd2},
      '{MODE_FAST_CAP, ACT_INV,    CS_DIV1,  16'h0004, 16'd16,   16'd22,   16'd2},
      '{MODE_FAST_CAP, ACT_NONINV, CS_DIV1,  16'h0000, 16'd16,   16'd2,    16'd2},
      '{MODE_FAST_CAP, ACT_NONINV, CS_DIV1,  16'h000f, 16'd16,   16'd32,   16'd0},
      '{MODE_FAST_CAP, ACT_INV,    CS_DIV1,  16'h000f, 16'd16,   16'd0,    16'd0},
      '{MODE_FAST_CAP, ACT_NONE,   CS_DIV1,  16'h0004, 16'd16,   16'hffff, 16'd0},
      '{MODE_FAST_CAP, ACT_NONINV, CS_DIV8,  16'h0004, 16'd128,  16'd80,   16'd2},
      '{MODE_FAST_CAP, ACT_NONINV, CS_DIV64, 16'h0004, 16'd1024, 16'd640,  16'd2},
      '{MODE_PC_CAP,   ACT_NONINV, CS_DIV1,  16'h0005, 16'd30,   16'd20,   16'd2},
      '{MODE_PC_CAP,   ACT_INV,    CS_DIV1,  16'h0005, 16'd30,   16'd40,   16'd2},
      '{MODE_PC_CAP,   ACT_NONINV, CS_DIV1,  16'h0000, 16'd30,   16'd0,    16'd0},
      '{MODE_PC_CAP,   ACT_NONINV, CS_DIV1,  16'h000f, 16'd30,   16'd60,   16'd0},
      '{MODE_PC_CAP,   ACT_INV,    CS_DIV1,  16'h000f, 16'd30,   16'd0,    16'd0},
      '{MODE_FAST8,    ACT_NONINV, CS_DIV1,  16'h0010, 16'd256,  16'd34,   16'd2},
      '{MODE_FAST9,    ACT_NONINV, CS_DIV1,  16'h0010, 16'd512,  16'd34,   16'd2},
      '{MODE_FAST10,   ACT_NONINV, CS_DIV1,  16'h0010, 16'd1024, 16'd34,   16'd2},
      '{MODE_PC8,      ACT_NONINV, CS_DIV1,  16'h0010, 16'd510,  16'd64,   16'd2},
      '{MODE_PC9,      ACT_NONINV, CS_DIV1,  16'h0010, 16'd1022, 16'd64,   16'd2},
      '{MODE_PC10,     ACT_NONINV, CS_DIV1,  16'h0010, 16'd2046, 16'd64,   16'd2}};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("ctrl_reset", OFF_CTRL, 16'h0000);
    rdchk("count_reset", OFF_COUNT, VALUE_RESET);
    rdchk("flags_reset", OFF_FLAGS, 16'h0000);
    rdchk("unmapped_read", 3'h6, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      wr(OFF_CTRL, ctrl(fm[i], ACT_NONE, ACT_NONE, CS_STOP, 1'b0));
      wr(OFF_CMP_A, 16'hffff);
      rdchk("masked_compare", OFF_CMP_A, ft[i]);
    end
    $display("test reset and masking done");
    // Variable TOP kept at or above three and at or above the table's compare B values
    // TOP is written while the timer is stopped, except the toggle test's buffered compare A write
    wr(OFF_CAPTURE, 16'h000f);
    foreach (tbl[i]) run_case(tbl[i]);
    $display("test waveform table done");
    wr(OFF_CTRL, ctrl(MODE_FAST_CAP, ACT_NONE, ACT_NONE, CS_STOP, 1'b0));
    wr(OFF_COUNT, 16'h000d);
    wr(OFF_FLAGS, 16'h000f);
    rdchk("flags_cleared", OFF_FLAGS, 16'h0000);
    wr(OFF_CTRL, ctrl(MODE_FAST_CAP, ACT_NONE, ACT_NONE, CS_DIV1, 1'b0));
    repeat (4) @(posedge clk);
    wr(OFF_CTRL, ctrl(MODE_FAST_CAP, ACT_NONE, ACT_NONE, CS_STOP, 1'b0));
    rd(OFF_FLAGS);
    chk("fast_top_flags", 16'h0009, rd_q & 16'h0009);
    wr(OFF_CTRL, ctrl(MODE_PC_CAP, ACT_NONE, ACT_NONE, CS_STOP, 1'b0));
    wr(OFF_COUNT, 16'h0000);
    wr(OFF_FLAGS, 16'h000f);
    wr(OFF_CTRL, ctrl(MODE_PC_CAP, ACT_NONE, ACT_NONE, CS_DIV1, 1'b0));
    repeat (40) @(posedge clk);
    wr(OFF_CTRL, ctrl(MODE_PC_CAP, ACT_NONE, ACT_NONE, CS_STOP, 1'b0));
    rd(OFF_FLAGS);
    chk("pc_flags", 16'h0009, rd_q & 16'h0009);
    wr(OFF_COUNT, 16'h0020);
    wr(OFF_CTRL, ctrl(MODE_FAST_CAP, ACT_NONE, ACT_NONE, CS_DIV1, 1'b0));
    repeat (10) @(posedge clk);
    wr(OFF_CTRL, ctrl(MODE_FAST_CAP, ACT_NONE, ACT_NONE, CS_STOP, 1'b0));
    rd(OFF_COUNT);
    chk("missed_top", 16'h0001, {15'h0000, rd_q > 16'h0020 && rd_q < 16'h0040});
    $display("test flags done");
    // Non-PWM mode loads compare A straight into the active register
    wr(OFF_CTRL, 16'h0000);
    wr(OFF_COUNT, 16'h0000);
    wr(OFF_CMP_A, 16'h0003);
    wr(OFF_CTRL, ctrl(MODE_FAST_CMPA, ACT_TOGGLE, ACT_NONE, CS_DIV1, 1'b1));
    repeat (32) @(posedge clk);
    measure(16);
    chk("pin_a_enable", 16'h0001, {15'h0000, wave_a_oe});
    chk("toggle_high", 16'd8, hi_a);
    chk("toggle_rises", 16'd2, rise_a);
    wr(OFF_CMP_A, 16'h0007);
    repeat (64) @(posedge clk);
    measure(32);
    chk("new_top_high", 16'd16, hi_a);
    chk("new_top_rises", 16'd2, rise_a);
    $display("test toggle done");
    report_and_stop();
  end
endmodule : tb_timer16_pwm
